// >>> verilog/pcx_pkg.sv
// Constants, field layouts and carrier types for the port crossbar enables
package pcx_pkg;

  // Sizes
  localparam int PCX_PINS = 24;
  localparam int PCX_FUNCS = 26;

  // Register addresses and reset values
  localparam logic [7:0] PCX_ADDR_ROUTE_A = 8'hE1;
  localparam logic [7:0] PCX_ADDR_ROUTE_B = 8'hE2;
  localparam logic [7:0] PCX_RST_ROUTE_A = 8'h00;
  localparam logic [6:0] PCX_RST_ROUTE_B = 7'h00;
  localparam logic [7:0] PCX_READ_NONE = 8'h00;

  // Field positions, crossbar_route_select_a
  localparam int PCX_A_CMPB_ASYNC = 7;
  localparam int PCX_A_CMPB = 6;
  localparam int PCX_A_CMPA_ASYNC = 5;
  localparam int PCX_A_CMPA = 4;
  localparam int PCX_A_SYSCLK = 3;
  localparam int PCX_A_TWOWIRE = 2;
  localparam int PCX_A_SPIA = 1;
  localparam int PCX_A_UART = 0;

  // Field positions, crossbar_route_select_b
  localparam int PCX_B_SPIB = 6;
  localparam int PCX_B_TIMERB = 5;
  localparam int PCX_B_TIMERA = 4;
  localparam int PCX_B_EXTCLK = 3;
  localparam int PCX_B_COUNT_LO = 0;
  localparam logic [2:0] PCX_COUNT_RESERVED = 3'h7;

  // Function indices, in crossbar priority order
  localparam int PCX_F_UART_TX = 0;
  localparam int PCX_F_UART_RX = 1;
  localparam int PCX_F_SPIB_SCK = 2;
  localparam int PCX_F_SPIB_SEL = 5;
  localparam int PCX_F_SPIA_SCK = 6;
  localparam int PCX_F_SPIA_SEL = 9;
  localparam int PCX_F_SDA = 10;
  localparam int PCX_F_SCL = 11;
  localparam int PCX_F_CMPA = 12;
  localparam int PCX_F_CMPA_ASYNC = 13;
  localparam int PCX_F_CMPB = 14;
  localparam int PCX_F_CMPB_ASYNC = 15;
  localparam int PCX_F_SYSCLK = 16;
  localparam int PCX_F_CH0 = 17;
  localparam int PCX_F_EXTCLK = 23;
  localparam int PCX_F_TIMERA = 24;
  localparam int PCX_F_TIMERB = 25;

  // Fixed pins: P0.4, P0.5, P2.0 to P2.3 (pin index = port * 8 + bit)
  localparam int PCX_PIN_UART_TX = 4;
  localparam int PCX_PIN_UART_RX = 5;
  localparam int PCX_PIN_SPIB_BASE = 16;
  localparam logic [25:0] PCX_FIXED_FUNCS = 26'h000003F;

  // Fixed functions that claim a given pin
  function automatic logic [25:0] pcx_fixed_mask(input int pin);
    logic [25:0] m;
    m = 26'h0000000;
    if (pin == PCX_PIN_UART_TX) m[PCX_F_UART_TX] = 1'b1;
    if (pin == PCX_PIN_UART_RX) m[PCX_F_UART_RX] = 1'b1;
    for (int k = 0; k < 4; k++)
      if (pin == PCX_PIN_SPIB_BASE + k) m[PCX_F_SPIB_SCK + k] = 1'b1;
    return m;
  endfunction

  // Special function register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic wrEn;
    logic rdEn;
    logic [7:0] wrData;
  } pcx_sfr_req_s;

endpackage

// >>> verilog/pcx_crossbar_enables.sv
// Port crossbar peripheral enables: route registers and pin assignment
`timescale 1ns/100ps
//
// Function
// - Async comparator outputs reach a pin only when their enable bit is one.
// - Clocked comparator outputs reach a pin only when their enable bit is one.
// - System clock drives a pin only while its enable bit is set.
// - Two-wire data and clock take pins only while their bit is set.
// - First SPI takes three pins, plus slave select in 4-wire mode.
// - UART transmit sits on P0.4 and receive on P0.5 when enabled.
// - Top bit of the second register reads zero and ignores writes.
// - Second SPI clock, MISO, MOSI sit fixed on P2.0, P2.1, P2.2.
// - Second SPI slave select takes P2.3 only in 4-wire mode.
// - Second timer input takes a pin only while its bit is set.
// - First timer input takes a pin only while its bit is set.
// - Counter array external clock takes a pin only while its bit is set.
// - Channel count N up to 6 routes counter array channels 0 to N-1; the reserved code 7 routes none.
// - Floating functions take the lowest free, unskipped pin in priority order.
// - All pin drivers stay off while the global crossbar enable is low.
// - Routed two-wire pins are always driven open-drain.
module pcx_crossbar_enables
  import pcx_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Special function register port
  input wire pcx_sfr_req_s sfrReq,
  output logic [7:0] sfrRdData,
  // Settings held by neighbouring port logic
  input wire logic crossbarGlobalEnable,
  input wire logic [23:0] pinSkipMask,
  input wire logic serialPortAFourWire,
  input wire logic serialPortBFourWire,
  // Peripheral side, one bit per function
  input wire logic [25:0] funcOut,
  input wire logic [25:0] funcOe,
  output logic [25:0] funcIn,
  // Plain port latch for unrouted pins
  input wire logic [23:0] gpioOut,
  input wire logic [23:0] gpioOe,
  // Pads
  input wire logic [23:0] pinIn,
  output logic [23:0] pinOut,
  output logic [23:0] pinOe,
  output logic [23:0] pinRouted
);

  // Number of set bits of v below position n
  function automatic logic [4:0] count_below(input logic [31:0] v, input int n);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 32; i++)
      if (i < n && v[i]) c = c + 5'h01;
    return c;
  endfunction

  logic [7:0] routeA_ff;
  logic [6:0] routeB_ff;
  logic [7:0] nxt_sfrRdData;
  logic [23:0] padMeta_ff;
  logic [23:0] padSync_ff;

  // Register decode
  logic hitA;
  logic hitB;
  assign hitA = sfrReq.addr == PCX_ADDR_ROUTE_A;
  assign hitB = sfrReq.addr == PCX_ADDR_ROUTE_B;

  // Route registers; the unused top bit of B is never stored
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      routeA_ff <= PCX_RST_ROUTE_A;
      routeB_ff <= PCX_RST_ROUTE_B;
    end
    else
    begin
      if (sfrReq.wrEn && hitA) routeA_ff <= sfrReq.wrData;
      if (sfrReq.wrEn && hitB) routeB_ff <= sfrReq.wrData[6:0];
    end
  end

  // Read data, one cycle after the strobe; other addresses read zero
  always_comb
  begin
    nxt_sfrRdData = PCX_READ_NONE;
    if (sfrReq.rdEn && hitA) nxt_sfrRdData = routeA_ff;
    else if (sfrReq.rdEn && hitB) nxt_sfrRdData = {1'b0, routeB_ff};
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) sfrRdData <= PCX_READ_NONE;
    else sfrRdData <= nxt_sfrRdData;
  end

  // Channel count; the reserved code routes nothing
  logic [2:0] chanCount;
  logic [2:0] chanLimit;
  assign chanCount = routeB_ff[PCX_B_COUNT_LO +: 3];
  assign chanLimit = (chanCount == PCX_COUNT_RESERVED) ? 3'h0 : chanCount;

  // Enable per function, in priority order
  logic [25:0] funcEn;
  logic spiAOn;
  logic spiBOn;
  assign spiAOn = routeA_ff[PCX_A_SPIA];
  assign spiBOn = routeB_ff[PCX_B_SPIB];
  assign funcEn[PCX_F_UART_TX] = routeA_ff[PCX_A_UART];
  assign funcEn[PCX_F_UART_RX] = routeA_ff[PCX_A_UART];
  assign funcEn[PCX_F_SPIB_SCK +: 3] = {3{spiBOn}};
  assign funcEn[PCX_F_SPIB_SEL] = spiBOn & serialPortBFourWire;
  assign funcEn[PCX_F_SPIA_SCK +: 3] = {3{spiAOn}};
  assign funcEn[PCX_F_SPIA_SEL] = spiAOn & serialPortAFourWire;
  assign funcEn[PCX_F_SDA] = routeA_ff[PCX_A_TWOWIRE];
  assign funcEn[PCX_F_SCL] = routeA_ff[PCX_A_TWOWIRE];
  assign funcEn[PCX_F_CMPA] = routeA_ff[PCX_A_CMPA];
  assign funcEn[PCX_F_CMPA_ASYNC] = routeA_ff[PCX_A_CMPA_ASYNC];
  assign funcEn[PCX_F_CMPB] = routeA_ff[PCX_A_CMPB];
  assign funcEn[PCX_F_CMPB_ASYNC] = routeA_ff[PCX_A_CMPB_ASYNC];
  assign funcEn[PCX_F_SYSCLK] = routeA_ff[PCX_A_SYSCLK];
  assign funcEn[PCX_F_EXTCLK] = routeB_ff[PCX_B_EXTCLK];
  assign funcEn[PCX_F_TIMERA] = routeB_ff[PCX_B_TIMERA];
  assign funcEn[PCX_F_TIMERB] = routeB_ff[PCX_B_TIMERB];

  // Counter array channels are cumulative from channel 0
  genvar ch;
  generate
    for (ch = 0; ch < 6; ch++)
    begin : gChan
      assign funcEn[PCX_F_CH0 + ch] = chanLimit > 3'(ch);
    end
  endgenerate

  // Floating functions ranked among the enabled ones
  logic [25:0] floatEn;
  logic [4:0] funcRank [PCX_FUNCS];
  assign floatEn = funcEn & ~PCX_FIXED_FUNCS;

  genvar f;
  generate
    for (f = 0; f < PCX_FUNCS; f++)
    begin : gRank
      assign funcRank[f] = count_below(32'(floatEn), f);
    end
  endgenerate

  // Pins held by enabled fixed functions are passed over like skipped ones
  logic [23:0] fixedClaim;
  logic [23:0] avail;
  logic [4:0] pinRank [PCX_PINS];
  logic [25:0] selRow [PCX_PINS];
  logic [23:0] selCol [PCX_FUNCS];
  logic [23:0] assigned;
  logic [23:0] openDrain;
  logic [23:0] drvOut;
  logic [23:0] drvOe;

  genvar p;
  generate
    for (p = 0; p < PCX_PINS; p++)
    begin : gPin
      logic [25:0] fixedSel;
      logic [25:0] floatSel;
      assign fixedSel = funcEn & pcx_fixed_mask(p);
      assign fixedClaim[p] = |fixedSel;
      assign avail[p] = ~pinSkipMask[p] & ~fixedClaim[p];
      assign pinRank[p] = count_below(32'(avail), p);
      // k-th enabled floating function lands on the k-th free pin
      for (f = 0; f < PCX_FUNCS; f++)
      begin : gMatch
        assign floatSel[f] = floatEn[f] & avail[p] & (funcRank[f] == pinRank[p]);
        assign selCol[f][p] = selRow[p][f];
      end
      assign selRow[p] = fixedSel | floatSel;
      assign assigned[p] = |selRow[p];
      assign openDrain[p] = selRow[p][PCX_F_SDA] | selRow[p][PCX_F_SCL];
      assign drvOut[p] = |(selRow[p] & funcOut);
      assign drvOe[p] = |(selRow[p] & funcOe);
    end
  endgenerate

  // Pad levels come from outside the clock domain
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      padMeta_ff <= 24'h000000;
      padSync_ff <= 24'h000000;
    end
    else
    begin
      padMeta_ff <= pinIn;
      padSync_ff <= padMeta_ff;
    end
  end

  // Pad level back to each routed function; unrouted inputs read zero
  logic [25:0] nxt_funcIn;
  generate
    for (f = 0; f < PCX_FUNCS; f++)
    begin : gIn
      assign nxt_funcIn[f] = |(selCol[f] & padSync_ff);
    end
  endgenerate

  // Pin drive, chosen pin by pin; two-wire pins only ever pull low
  // Bitwise select, so one routed pin never drags the other pads off gpio
  logic [23:0] nxt_pinOut;
  logic [23:0] nxt_pinOe;
  logic [23:0] rawOe;
  logic [23:0] routedOe;
  assign nxt_pinOut = (assigned & drvOut & ~openDrain) | (~assigned & gpioOut);
  assign routedOe = (openDrain & ~drvOut) | (~openDrain & drvOe);
  assign rawOe = (assigned & routedOe) | (~assigned & gpioOe);
  assign nxt_pinOe = crossbarGlobalEnable ? rawOe : 24'h000000;

  // Pin and function registers; costs one cycle, including on the async
  // comparator path, so that outputs leave glitch free from a flop
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinOut <= 24'h000000;
      pinOe <= 24'h000000;
      pinRouted <= 24'h000000;
      funcIn <= 26'h0000000;
    end
    else
    begin
      pinOut <= nxt_pinOut;
      pinOe <= nxt_pinOe;
      pinRouted <= assigned;
      funcIn <= nxt_funcIn;
    end
  end

endmodule

// >>> verif/pcx_crossbar_checker.sv
// Port checks for the crossbar enables
`timescale 1ns/100ps
module pcx_crossbar_checker
  import pcx_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port and settings
  input wire pcx_sfr_req_s sfrReq,
  input wire logic [7:0] sfrRdData,
  input wire logic crossbarGlobalEnable,
  input wire logic [23:0] pinSkipMask,
  input wire logic serialPortBFourWire,
  // Function and pad side
  input wire logic [25:0] funcOut,
  input wire logic [23:0] pinOut,
  input wire logic [23:0] pinOe,
  input wire logic [23:0] pinRouted
);
  logic [7:0] regA_ff;
  logic [6:0] regB_ff;
  // Mirror decode; pads lag the registers by one cycle
  wire wrA = sfrReq.wrEn && sfrReq.addr == PCX_ADDR_ROUTE_A;
  wire wrB = sfrReq.wrEn && sfrReq.addr == PCX_ADDR_ROUTE_B;
  wire live = crossbarGlobalEnable && pinSkipMask == 24'h000000;
  wire soloA = live && regB_ff == 7'h00;
  wire onlyCnt = live && regA_ff == 8'h00 && regB_ff[6:3] == 4'h0;
  wire [23:0] cntMask = regB_ff[2:0] == PCX_COUNT_RESERVED ? 24'h000000 :
    (24'h000001 << regB_ff[2:0]) - 24'h000001;
  // Mirror of both route registers, top bit of the second one never stored
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      regA_ff <= PCX_RST_ROUTE_A;
      regB_ff <= PCX_RST_ROUTE_B;
    end
    else
    begin
      if (wrA) regA_ff <= sfrReq.wrData;
      if (wrB) regB_ff <= sfrReq.wrData[6:0];
    end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_noDrive; !crossbarGlobalEnable |=> pinOe == 24'h000000; endproperty
  a_noDrive: assert property (p_noDrive) else $error("pad driven while off");
  property p_readB; sfrReq.rdEn && !sfrReq.wrEn && !wrB && sfrReq.addr == PCX_ADDR_ROUTE_B
    |=> sfrRdData == {1'b0, regB_ff}; endproperty
  a_readB: assert property (p_readB) else $error("second register readback");
  property p_uart; crossbarGlobalEnable && regA_ff[PCX_A_UART]
    |=> pinRouted[5:4] == 2'b11 && pinOut[4] == $past(funcOut[0]); endproperty
  a_uart: assert property (p_uart) else $error("uart pins");
  property p_spiB; crossbarGlobalEnable && regB_ff[PCX_B_SPIB]
    |=> &pinRouted[18:16] && pinOut[18:16] == $past(funcOut[4:2]); endproperty
  a_spiB: assert property (p_spiB) else $error("second spi pins");
  property p_spiBSel; crossbarGlobalEnable && regB_ff[PCX_B_SPIB] && serialPortBFourWire
    |=> pinRouted[19] && pinOut[19] == $past(funcOut[5]); endproperty
  a_spiBSel: assert property (p_spiBSel) else $error("second spi select");
  property p_count; onlyCnt |=> pinRouted == $past(cntMask); endproperty
  a_count: assert property (p_count) else $error("channel pins");
  property p_sysclk; soloA && regA_ff == 8'h08
    |=> pinRouted == 24'h000001 && pinOut[0] == $past(funcOut[PCX_F_SYSCLK]); endproperty
  a_sysclk: assert property (p_sysclk) else $error("clock out pin");
  property p_openDrain; soloA && regA_ff == 8'h04
    |=> pinOut[1:0] == 2'b00 && pinOe[1:0] == ~$past(funcOut[11:10]); endproperty
  a_openDrain: assert property (p_openDrain) else $error("two-wire drive");
endmodule

// >>> verif/pcx_pin_partner.sv
// Board circuitry facing the crossbar pads
`timescale 1ns/100ps
module pcx_pin_partner
(
  // Drive from the block
  input wire logic [23:0] pinOut,
  input wire logic [23:0] pinOe,
  // Board level on released pads, pull-ups or an outside driver
  input wire logic [23:0] boardLevel,
  // Pad level seen by the block
  output logic [23:0] pinIn
);
  // A released pad never keeps the block's last value
  assign pinIn = (pinOe & pinOut) | (~pinOe & boardLevel);
endmodule

// >>> verif/tb.sv
// Self-checking bench for the crossbar enables
`timescale 1ns/100ps
module tb
  import pcx_pkg::*;
;
  logic mclk, rst_n, crossbarGlobalEnable, serialPortAFourWire, serialPortBFourWire;
  pcx_sfr_req_s sfrReq;
  logic [7:0] sfrRdData;
  logic [25:0] funcOut, funcOe, funcIn;
  logic [23:0] pinSkipMask, gpioOut, gpioOe, boardLevel, pinIn, pinOut, pinOe, pinRouted;
  int n_fail = 0, tests_run = 0;
  logic [15:0] soloCfg [8] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0020,
    16'h0010, 16'h0008};
  int soloFunc [8] = '{15, 14, 13, 12, 16, 25, 24, 23};
  pcx_crossbar_enables pcx_crossbar_enables_inst (.mclk, .rst_n, .sfrReq, .sfrRdData,
    .crossbarGlobalEnable, .pinSkipMask, .serialPortAFourWire, .serialPortBFourWire, .funcOut,
    .funcOe, .funcIn, .gpioOut, .gpioOe, .pinIn, .pinOut, .pinOe, .pinRouted);
  pcx_pin_partner pcx_pin_partner_inst (.pinOut, .pinOe, .boardLevel, .pinIn);
  // Clock, 50 ns period
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Back-to-back writes keep the strobe up; settle covers pad and sync latency
  task automatic cfg(input logic [7:0] a, input logic [7:0] b);
    @(negedge mclk);
    sfrReq = '{PCX_ADDR_ROUTE_A, 1'b1, 1'b0, a};
    @(negedge mclk);
    sfrReq = '{PCX_ADDR_ROUTE_B, 1'b1, 1'b0, b};
    @(negedge mclk);
    sfrReq.wrEn = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge mclk);
    sfrReq = '{addr, 1'b0, 1'b1, 8'h00};
    @(negedge mclk);
    check(sfrRdData, exp);
    sfrReq.rdEn = 1'b0;
  endtask
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Reset, fixed pins, floating pins, then register corner cases
  initial
  begin
    sfrReq = '{8'h00, 1'b0, 1'b0, 8'h00};
    rst_n = 1'b0;
    crossbarGlobalEnable = 1'b0;
    pinSkipMask = 24'h000000;
    serialPortAFourWire = 1'b0;
    serialPortBFourWire = 1'b1;
    funcOut = 26'h0000000;
    funcOe = 26'h3FFFFFF;
    gpioOut = 24'hFFFFFF;
    gpioOe = 24'hFFFFFF;
    boardLevel = 24'hFFFFFF;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    read_check(PCX_ADDR_ROUTE_A, 8'h00);
    read_check(PCX_ADDR_ROUTE_B, 8'h00);
    cfg(8'h01, 8'h40);
    check(pinOe, 24'h000000);
    crossbarGlobalEnable = 1'b1;
    pinSkipMask = 24'hFFFFFF;
    funcOut = 26'h0000014;
    repeat (3) @(negedge mclk);
    check(pinRouted, 24'h0F0030);
    check({pinOut[19:16], pinOut[4], pinOut[0]}, 6'b010101);
    serialPortBFourWire = 1'b0;
    repeat (3) @(negedge mclk);
    check(pinRouted, 24'h070030);
    pinSkipMask = 24'h000005;
    cfg(8'h00, 8'h02);
    check(pinRouted, 24'h00000A);
    pinSkipMask = 24'h000000;
    funcOut = 26'h0000800;
    cfg(8'h04, 8'h00);
    check({pinRouted[1:0], pinOut[2:0], pinOe[2:0]}, 8'b11100101);
    for (int k = 0; k < 2; k++)
    begin
      serialPortAFourWire = k[0];
      cfg(8'h02, 8'h00);
      check(pinRouted, k ? 24'h00000F : 24'h000007);
    end
    // Each lone function lands on the lowest pad; inputs read the board level
    for (int k = 0; k < 8; k++)
    begin
      funcOut = 26'h0000001 << soloFunc[k];
      funcOe = k < 5 ? funcOut : 26'h0000000;
      cfg(soloCfg[k][15:8], soloCfg[k][7:0]);
      check(pinRouted, 24'h000001);
      check(k < 5 ? {pinOut[0], pinOe[0]} : funcIn, k < 5 ? 2'b11 : funcOut);
    end
    for (int k = 0; k < 8; k++)
    begin
      cfg(8'h00, k[7:0]);
      check(pinRouted, k == 7 ? 24'h000000 : (24'h000001 << k) - 24'h000001);
    end
    cfg(8'hA5, 8'hFF);
    read_check(PCX_ADDR_ROUTE_B, 8'h7F);
    @(negedge mclk);
    sfrReq = '{8'hE3, 1'b1, 1'b0, 8'h5A};
    @(negedge mclk);
    sfrReq.wrEn = 1'b0;
    read_check(8'hE3, 8'h00);
    read_check(PCX_ADDR_ROUTE_A, 8'hA5);
    end_of_test();
  end
  // Watchdog at 2000 cycles, well past the under two hundred cycles the cases need
  initial
  begin
    #(50 * 2000);
    n_fail++;
    end_of_test();
  end
endmodule
bind pcx_crossbar_enables pcx_crossbar_checker pcx_crossbar_checker_inst (.mclk, .rst_n,
  .sfrReq, .sfrRdData, .crossbarGlobalEnable, .pinSkipMask, .serialPortBFourWire, .funcOut,
  .pinOut, .pinOe, .pinRouted);
